// file: hdl/tmr16_regs.vh
/*
 * Constants for the 16-bit timer/event counter with two
 * capture/compare registers.
 * Assumes inclusion by bare name from the timer design files.
 */
// Notes on behaviour
// R1: Output off in edge-clear mode with pin2.
// R2: PPG duty value below period value.
// R3: One-shot compares must differ.
// R4: Output off during pulse width measurement.
// R5: First match may lag one count clock.
// R6: Compare-clear mode needs nonzero compare values.
// R7: Capture proceeds during read; valid edges interrupt.
// R8: Read capture only after its interrupt.
// R9: Compare registers undefined after stop.
// R10: Change pin1 edge select only when stopped.
// R11: No one-shot retrigger during active level.
// R12: Overflow flag on wrap, incl. FFFF compare-clear.
// R13: Overflow clear before count one is ineffective.
// R14: One-shot absent in compare-clear mode.
// R15: Pin1 capture unreliable when pin1 clocks.
// R16: Capture pulses wider than two count clocks.
// R17: Capture at fall, interrupt next rise.
// R18: Reverse capture: no irq; pin2 edge interrupts.
// R19: First start treats high level as rise.
// R20: Two equal samples accept an edge.
// R21: Pins ignored while stopped.
// R22: Counter read through count-up buffer.
// R23: Mode 00 stops the timer.
// R24: Mode 01 free-running.
// R25: Mode 10 capture and clear on pin1.
// R26: Mode 11 clear on period match.
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH
`define TMR16_W         16
`define TMR16_CNT_MAX   16'hFFFF
`define TMR16_CNT_RST   16'h0000
`define TMR16_REG_RST   16'h0000
`define TMR16_MODE_STOP 2'h0
`define TMR16_MODE_FREE 2'h1
`define TMR16_MODE_EDGE 2'h2
`define TMR16_MODE_CMP  2'h3
`define TMR16_ES_FALL   2'h0
`define TMR16_ES_RISE   2'h1
`define TMR16_ES_NONE   2'h2
`define TMR16_ES_BOTH   2'h3
`define TMR16_PSC_DIV2  2'h0
`define TMR16_PSC_DIV4  2'h1
`define TMR16_PSC_DIV16 2'h2
`define TMR16_PSC_PIN   2'h3
`define TMR16_PSC_RST   4'h0
`define TMR16_RISE_2    1'h0
`define TMR16_FALL_2    1'h1
`define TMR16_RISE_4    2'h0
`define TMR16_FALL_4    2'h2
`define TMR16_RISE_16   4'h0
`define TMR16_FALL_16   4'h8
`endif

// file: hdl/tmr16_edge.v
/*
 * Pin edge detector: three-stage synchroniser, two-sample
 * noise filter and edge-select decode.
 * Assumes the sample strobe comes from the same clock.
 */
`timescale 1ns/1ps
`include "tmr16_regs.vh"
module tmr16_edge
(
    input  wire       ref_clk_i,
    input  wire       nrst_i,
    input  wire       clk_en_i,
    input  wire       pin_i,
    input  wire       sample_en_i,
    input  wire       run_i,
    input  wire       start_i,
    input  wire [1:0] edge_sel_i,
    output reg        valid_edge_o,
    output reg        rev_edge_o
);
    reg       s1;
    reg       s2;
    reg       s3;
    reg       lvl;
    reg       smp;
    reg       filt;
    reg       started;
    wire      samp;
    wire      rise;
    wire      fall;

    // Pins ignored while stopped
    assign samp = run_i & sample_en_i; // see R21
    // Two equal samples accept a new level
    assign rise = samp & (smp == lvl) & lvl & ~filt; // see R20
    assign fall = samp & (smp == lvl) & ~lvl & filt; // see R20

    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1           <= 1'b0;
            s2           <= 1'b0;
            s3           <= 1'b0;
            lvl          <= 1'b0;
            smp          <= 1'b0;
            filt         <= 1'b0;
            started      <= 1'b0;
            valid_edge_o <= 1'b0;
            rev_edge_o   <= 1'b0;
        end
        else if (clk_en_i)
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                lvl <= s3;
            if (start_i)
                started <= 1'b1;
            // Later restarts take the level as it stands
            if (start_i && started)
            begin
                smp  <= lvl; // see R19
                filt <= lvl; // see R19
            end
            else if (samp)
            begin
                smp <= lvl;
                if (smp == lvl)
                    filt <= lvl;
            end
            case (edge_sel_i)
                `TMR16_ES_FALL:
                begin
                    valid_edge_o <= fall;
                    rev_edge_o   <= rise;
                end
                `TMR16_ES_RISE:
                begin
                    valid_edge_o <= rise;
                    rev_edge_o   <= fall;
                end
                `TMR16_ES_BOTH:
                begin
                    valid_edge_o <= rise | fall;
                    rev_edge_o   <= 1'b0;
                end
                default:
                begin
                    valid_edge_o <= 1'b0;
                    rev_edge_o   <= 1'b0;
                end
            endcase
        end
    end
endmodule // tmr16_edge

// file: hdl/tmr16_core.v
/*
 * 16-bit timer/event counter with two capture/compare
 * registers, overflow flag, output pin and two input pins.
 * Assumes control bits held steady by software; pins are
 * asynchronous and go through the edge detectors.
 */
`timescale 1ns/1ps
`include "tmr16_regs.vh"
module tmr16_core
(
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire        clk_en_i,
    input  wire [1:0]  op_mode_i,
    input  wire [1:0]  prescale_sel_i,
    input  wire        edge_select_low_i,
    input  wire        edge_select_high_i,
    input  wire [1:0]  second_edge_sel_i,
    input  wire        period_capture_en_i,
    input  wire        reverse_phase_capture_sel_i,
    input  wire        duty_capture_en_i,
    input  wire        period_wr_i,
    input  wire        duty_wr_i,
    input  wire [15:0] wdata_i,
    input  wire        overflow_clr_i,
    input  wire        out_enable_i,
    input  wire        toggle_on_period_i,
    input  wire        toggle_on_duty_i,
    input  wire        one_shot_en_i,
    input  wire        one_shot_pin_trig_en_i,
    input  wire        one_shot_trig_i,
    input  wire        first_input_pin_i,
    input  wire        second_input_pin_i,
    output reg  [15:0] count_value_o,
    output reg  [15:0] period_capture_reg_o,
    output reg  [15:0] duty_capture_reg_o,
    output reg         overflow_flag_o,
    output reg         first_capture_irq_o,
    output reg         second_capture_irq_o,
    output reg         timer_output_pin_o
);
    reg  [3:0]  psc;
    reg  [15:0] count;
    reg  [15:0] next_count;
    reg         run_d;
    reg         ovf_hold;
    reg         pend0;
    reg         pend1;
    reg         armed;
    reg         rise_tick;
    reg         fall_tick;
    wire        run;
    wire        start;
    wire        pin_clk;
    wire        tick;
    wire        s1_valid;
    wire        s1_rev;
    wire        s2_valid;
    wire        s2_rev;
    wire        edge_clr;
    wire        os_ok;
    wire        os_trig;
    wire        match0;
    wire        match1;
    wire        ovf_evt;
    wire        cap0_valid;
    wire        cap0_rev;
    wire        cap1;
    wire        ext_irq0;

    // Mode 00 stops, any other value runs
    assign run     = op_mode_i != `TMR16_MODE_STOP; // see R23
    assign start   = run & ~run_d;
    assign pin_clk = prescale_sel_i == `TMR16_PSC_PIN;

    // Prescaler never restarts, so the first count may lag
    always @*
    begin
        case (prescale_sel_i) // see R5
            `TMR16_PSC_DIV2:
            begin
                rise_tick = psc[0] == `TMR16_RISE_2;
                fall_tick = psc[0] == `TMR16_FALL_2;
            end
            `TMR16_PSC_DIV4:
            begin
                rise_tick = psc[1:0] == `TMR16_RISE_4;
                fall_tick = psc[1:0] == `TMR16_FALL_4;
            end
            `TMR16_PSC_DIV16:
            begin
                rise_tick = psc == `TMR16_RISE_16;
                fall_tick = psc == `TMR16_FALL_16;
            end
            default:
            begin
                rise_tick = s1_valid;
                fall_tick = s1_valid;
            end
        endcase
    end

    assign tick = run & rise_tick;

    // Pin clock samples every cycle, captures at count clock
    tmr16_edge u_first
    (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .clk_en_i    (clk_en_i),
        .pin_i       (first_input_pin_i),
        .sample_en_i (pin_clk | fall_tick), // see R20
        .run_i       (run),
        .start_i     (start),
        .edge_sel_i  ({edge_select_high_i, edge_select_low_i}),
        .valid_edge_o(s1_valid),
        .rev_edge_o  (s1_rev)
    );

    tmr16_edge u_second
    (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .clk_en_i    (clk_en_i),
        .pin_i       (second_input_pin_i),
        .sample_en_i (pin_clk | fall_tick), // see R20
        .run_i       (run),
        .start_i     (start),
        .edge_sel_i  (second_edge_sel_i),
        .valid_edge_o(s2_valid),
        .rev_edge_o  (s2_rev)
    );

    // Mode 10 clears on the first pin valid edge, except when the first pin is the count clock
    assign edge_clr = run & (op_mode_i == `TMR16_MODE_EDGE)
                    & ~pin_clk & s1_valid; // see R25

    // One-shot only in free-running or edge-clear mode
    assign os_ok   = run & one_shot_en_i
                   & (op_mode_i != `TMR16_MODE_CMP); // see R14
    assign os_trig = os_ok & (one_shot_trig_i
                   | (one_shot_pin_trig_en_i & s1_valid));

    assign match0 = tick & ~period_capture_en_i
                  & (count == period_capture_reg_o);
    assign match1 = tick & ~duty_capture_en_i
                  & (count == duty_capture_reg_o);

    // Capture sources for both registers
    assign cap0_valid = run & period_capture_en_i
                      & ~reverse_phase_capture_sel_i & s2_valid;
    assign cap0_rev   = run & period_capture_en_i
                      & reverse_phase_capture_sel_i & s1_rev;
    assign cap1       = run & duty_capture_en_i & s1_valid;
    // Reverse capture mode: pin2 edge is a plain interrupt
    assign ext_irq0   = run & period_capture_en_i
                      & reverse_phase_capture_sel_i
                      & s2_valid; // see R18

    // Overflow on wrap; compare-clear from max also wraps
    assign ovf_evt = tick & (count == `TMR16_CNT_MAX)
                   & ~edge_clr & ~os_trig; // see R12

    always @*
    begin
        if (!run)
            next_count = `TMR16_CNT_RST; // see R23
        else if (edge_clr || os_trig)
            next_count = `TMR16_CNT_RST; // see R25
        else if (tick && (op_mode_i == `TMR16_MODE_CMP)
                 && (count == period_capture_reg_o))
            next_count = `TMR16_CNT_RST; // see R26
        else if (tick)
            next_count = count + 16'h0001; // see R24
        else
            next_count = count;
    end

    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            psc                  <= `TMR16_PSC_RST;
            count                <= `TMR16_CNT_RST;
            count_value_o        <= `TMR16_CNT_RST;
            run_d                <= 1'b0;
        end
        else if (clk_en_i)
        begin
            psc   <= psc + 4'h1;
            run_d <= run;
            count <= next_count;
            // Read buffer follows each count-up, and loads zero while stopped
            if (tick || !run)
                count_value_o <= next_count; // see R22
        end
    end

    // Overflow flag, set wins over a software clear
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ovf_hold        <= 1'b0;
            overflow_flag_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            // Clear is ignored until the count reaches one
            if (ovf_evt)
                ovf_hold <= 1'b1; // see R13
            else if (tick || !run)
                ovf_hold <= 1'b0;
            if (ovf_evt || ovf_hold)
                overflow_flag_o <= 1'b1; // see R13
            else if (overflow_clr_i)
                overflow_flag_o <= 1'b0;
        end
    end

    // Capture interrupts, dropped while stopped
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pend0                <= 1'b0;
            pend1                <= 1'b0;
            first_capture_irq_o  <= 1'b0;
            second_capture_irq_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            // Capture latched now, interrupt at next rise
            if (cap0_valid || ext_irq0)
                pend0 <= 1'b1; // see R17
            else if (rise_tick || !run)
                pend0 <= 1'b0; // see R21
            if (cap1)
                pend1 <= 1'b1; // see R17
            else if (rise_tick || !run)
                pend1 <= 1'b0; // see R21
            // Reverse-phase captures raise nothing
            first_capture_irq_o  <= match0
                | (pend0 & rise_tick & run); // see R7
            second_capture_irq_o <= match1
                | (pend1 & rise_tick & run); // see R7
        end
    end

    // Capture wins over a software write in the same cycle
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            period_capture_reg_o <= `TMR16_REG_RST;
            duty_capture_reg_o   <= `TMR16_REG_RST;
        end
        else if (clk_en_i)
        begin
            // Captures go ahead even during a read
            if (cap0_valid || cap0_rev)
                period_capture_reg_o <= count; // see R7
            else if (period_wr_i)
                period_capture_reg_o <= wdata_i;
            if (cap1)
                duty_capture_reg_o <= count; // see R7
            else if (duty_wr_i)
                duty_capture_reg_o <= wdata_i;
            // Contents left as they are on stop; not relied on
        end // see R9
    end

    // Output pin: toggles, PPG and one-shot
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            timer_output_pin_o <= 1'b0;
            armed              <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (!out_enable_i || !run)
            begin
                timer_output_pin_o <= 1'b0;
                armed              <= 1'b0;
            end
            else if (one_shot_en_i)
            begin
                if (os_trig)
                    armed <= 1'b1; // see R14
                else if (armed && match0)
                begin
                    armed              <= 1'b0;
                    timer_output_pin_o <= 1'b0;
                end
                else if (armed && match1)
                    timer_output_pin_o <= 1'b1;
            end
            else if ((match0 && toggle_on_period_i)
                     ^ (match1 && toggle_on_duty_i))
                timer_output_pin_o <= ~timer_output_pin_o;
        end
    end
endmodule // tmr16_core

// file: tb/tmr16_core_checker.sv
/*
 * Port assertions for the 16-bit timer core.
 * Assumes one clock and an async active-low reset.
 */
`timescale 1ns/1ps
`include "tmr16_regs.vh"
module tmr16_core_checker
(
    input wire        ref_clk_i,
    input wire        nrst_i,
    input wire        clk_en_i,
    input wire [1:0]  op_mode_i,
    input wire [1:0]  prescale_sel_i,
    input wire        period_capture_en_i,
    input wire        period_wr_i,
    input wire [15:0] wdata_i,
    input wire        overflow_clr_i,
    input wire        out_enable_i,
    input wire        one_shot_en_i,
    input wire [15:0] count_value_o,
    input wire [15:0] period_capture_reg_o,
    input wire        overflow_flag_o,
    input wire        first_capture_irq_o,
    input wire        second_capture_irq_o,
    input wire        timer_output_pin_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire stopped = clk_en_i && op_mode_i == `TMR16_MODE_STOP;
    wire free_run = clk_en_i && op_mode_i == `TMR16_MODE_FREE && !one_shot_en_i;

    chk_stop_clears: assert property (stopped[*3] |-> count_value_o == 16'h0000)
        else $error("count not zero while stopped");
    chk_stop_quiet: assert property (stopped[*4]
        |-> !first_capture_irq_o && !second_capture_irq_o)
        else $error("interrupt while stopped");
    chk_ovf_clear_only: assert property ($fell(overflow_flag_o)
        |-> $past(overflow_clr_i)) else $error("overflow flag dropped by itself");
    chk_ovf_on_wrap: assert property (free_run && $stable(op_mode_i)
        && $past(count_value_o) == 16'hFFFF && count_value_o == 16'h0000
        |-> ##[0:2] overflow_flag_o) else $error("no overflow on wrap");
    chk_irq1_pulse: assert property (first_capture_irq_o
        |=> !first_capture_irq_o) else $error("first irq longer than a cycle");
    chk_irq2_pulse: assert property (second_capture_irq_o
        |=> !second_capture_irq_o) else $error("second irq longer than a cycle");
    chk_out_off: assert property ((!out_enable_i)[*2]
        |-> !timer_output_pin_o) else $error("output driven while disabled");
    chk_count_step: assert property (free_run && $stable(op_mode_i)
        && $changed(count_value_o)
        |-> count_value_o == $past(count_value_o) + 16'h0001)
        else $error("count did not step by one");
    chk_div2_rate: assert property (free_run && $stable(op_mode_i)
        && prescale_sel_i == `TMR16_PSC_DIV2 && $stable(prescale_sel_i)
        && $changed(count_value_o) |=> $stable(count_value_o))
        else $error("count faster than half clock");
    chk_period_write: assert property (clk_en_i && period_wr_i && stopped
        && !period_capture_en_i |=> period_capture_reg_o == $past(wdata_i))
        else $error("period write lost");

    cover property (first_capture_irq_o);
    cover property (second_capture_irq_o);
    cover property (timer_output_pin_o);
    cover property (period_wr_i && stopped);
endmodule // tmr16_core_checker

bind tmr16_core tmr16_core_checker u_chk
(
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
    .op_mode_i(op_mode_i), .prescale_sel_i(prescale_sel_i),
    .period_capture_en_i(period_capture_en_i), .period_wr_i(period_wr_i),
    .wdata_i(wdata_i), .overflow_clr_i(overflow_clr_i),
    .out_enable_i(out_enable_i), .one_shot_en_i(one_shot_en_i),
    .count_value_o(count_value_o),
    .period_capture_reg_o(period_capture_reg_o),
    .overflow_flag_o(overflow_flag_o),
    .first_capture_irq_o(first_capture_irq_o),
    .second_capture_irq_o(second_capture_irq_o),
    .timer_output_pin_o(timer_output_pin_o)
);

// file: tb/tmr16_pin_model.sv
/*
 * Model of the two external input pins of the timer.
 * Assumes the bench calls one task at a time.
 */
`timescale 1ns/1ps
module tmr16_pin_model
#(
    parameter MIN_W = 12
)
(
    input  wire ref_clk_i,
    output reg  first_input_pin_o,
    output reg  second_input_pin_o
);
    initial
    begin
        first_input_pin_o = 1'b0;
        second_input_pin_o = 1'b0;
    end
    // Steady level on one pin
    task level(input integer which, input v);
        begin
            if (which == 1)
                first_input_pin_o = v;
            else
                second_input_pin_o = v;
        end
    endtask
    // Wide pulse, or a one-cycle glitch
    task pulse(input integer which, input narrow);
        integer w;
        begin
            w = narrow ? 1 : MIN_W;
            @(negedge ref_clk_i);
            level(which, 1'b1);
            repeat (w) @(negedge ref_clk_i);
            level(which, 1'b0);
            repeat (MIN_W) @(negedge ref_clk_i);
        end
    endtask
endmodule // tmr16_pin_model

// file: tb/tb_tmr16_core.sv
/*
 * Self-checking bench for the 16-bit timer core.
 * Assumes the pin model drives both input pins.
 */
`timescale 1ns/1ps
`include "tmr16_regs.vh"
module tb_tmr16_core;
    reg        ref_clk_i = 1'b0, nrst_i = 1'b0;
    reg [1:0]  op_mode_i = 2'h0, prescale_sel_i = 2'h0, second_edge_sel_i = 2'h2;
    reg        edge_select_low_i = 1'b1, edge_select_high_i = 1'b0;
    reg        period_capture_en_i = 1'b0, duty_capture_en_i = 1'b0;
    reg        reverse_phase_capture_sel_i = 1'b0, one_shot_pin_trig_en_i = 1'b0;
    reg        period_wr_i = 1'b0, duty_wr_i = 1'b0, overflow_clr_i = 1'b0;
    reg [15:0] wdata_i = 16'h0000;
    reg        out_enable_i = 1'b0, one_shot_en_i = 1'b0, one_shot_trig_i = 1'b0;
    reg        toggle_on_period_i = 1'b0, toggle_on_duty_i = 1'b0;
    wire       first_input_pin_i, second_input_pin_i, timer_output_pin_o;
    wire [15:0] count_value_o, period_capture_reg_o, duty_capture_reg_o;
    wire       overflow_flag_o, first_capture_irq_o, second_capture_irq_o;
    integer    n_mismatch = 0, tests_run = 0, n1, n2, k;
    reg [15:0] cmax, saved;
    reg        hi;
    reg [33:0] rows [0:2];

    always #20 ref_clk_i = ~ref_clk_i;

    tmr16_core u_tmr16_core
    (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
        .op_mode_i(op_mode_i), .prescale_sel_i(prescale_sel_i),
        .edge_select_low_i(edge_select_low_i),
        .edge_select_high_i(edge_select_high_i),
        .second_edge_sel_i(second_edge_sel_i),
        .period_capture_en_i(period_capture_en_i),
        .reverse_phase_capture_sel_i(reverse_phase_capture_sel_i),
        .duty_capture_en_i(duty_capture_en_i), .period_wr_i(period_wr_i),
        .duty_wr_i(duty_wr_i), .wdata_i(wdata_i),
        .overflow_clr_i(overflow_clr_i), .out_enable_i(out_enable_i),
        .toggle_on_period_i(toggle_on_period_i),
        .toggle_on_duty_i(toggle_on_duty_i), .one_shot_en_i(one_shot_en_i),
        .one_shot_pin_trig_en_i(one_shot_pin_trig_en_i),
        .one_shot_trig_i(one_shot_trig_i),
        .first_input_pin_i(first_input_pin_i),
        .second_input_pin_i(second_input_pin_i),
        .count_value_o(count_value_o),
        .period_capture_reg_o(period_capture_reg_o),
        .duty_capture_reg_o(duty_capture_reg_o),
        .overflow_flag_o(overflow_flag_o),
        .first_capture_irq_o(first_capture_irq_o),
        .second_capture_irq_o(second_capture_irq_o),
        .timer_output_pin_o(timer_output_pin_o)
    );

    tmr16_pin_model u_pins
    (
        .ref_clk_i(ref_clk_i),
        .first_input_pin_o(first_input_pin_i),
        .second_input_pin_o(second_input_pin_i)
    );

    task test_done;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task check(input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // Count irq pulses, peak count and output high over n cycles
    task watch(input integer n);
        integer j;
        begin
            n1 = 0;
            n2 = 0;
            cmax = 16'h0000;
            hi = 1'b0;
            for (j = 0; j < n; j = j + 1)
            begin
                @(negedge ref_clk_i);
                if (first_capture_irq_o === 1'b1) n1 = n1 + 1;
                if (second_capture_irq_o === 1'b1) n2 = n2 + 1;
                if (count_value_o > cmax) cmax = count_value_o;
                if (timer_output_pin_o === 1'b1) hi = 1'b1;
            end
        end
    endtask

    task go(input [1:0] m);
        begin
            @(negedge ref_clk_i);
            op_mode_i = m;
        end
    endtask

    task wr(input p, input [15:0] v);
        begin
            @(negedge ref_clk_i);
            wdata_i = v;
            period_wr_i = p;
            duty_wr_i = !p;
            @(negedge ref_clk_i);
            period_wr_i = 1'b0;
            duty_wr_i = 1'b0;
        end
    endtask

    // Software trigger, only once the active level has ended
    task trig;
        integer j;
        begin
            for (j = 0; j < 100 && timer_output_pin_o !== 1'b0; j = j + 1)
                @(negedge ref_clk_i);
            check(j < 100, 1'b1);
            if (j == 100) test_done;
            one_shot_trig_i = 1'b1;
            @(negedge ref_clk_i);
            one_shot_trig_i = 1'b0;
        end
    endtask

    initial
    begin
        rows[0] = {`TMR16_PSC_DIV2, 16'h001E, 16'h0021};
        rows[1] = {`TMR16_PSC_DIV4, 16'h000E, 16'h0011};
        rows[2] = {`TMR16_PSC_DIV16, 16'h0002, 16'h0005};
        repeat (19) @(negedge ref_clk_i);
        check(count_value_o | period_capture_reg_o
            | duty_capture_reg_o, 16'h0000);
        check({overflow_flag_o, first_capture_irq_o,
            second_capture_irq_o, timer_output_pin_o}, 4'h0);
        u_pins.level(1, 1'b1);
        @(negedge ref_clk_i);
        nrst_i = 1'b1;
        duty_capture_en_i = 1'b1;
        op_mode_i = `TMR16_MODE_FREE;
        watch(40);
        check(n2, 1);
        go(`TMR16_MODE_STOP);
        watch(4);
        go(`TMR16_MODE_FREE);
        watch(40);
        check(n2, 0);
        go(`TMR16_MODE_STOP);
        u_pins.level(1, 1'b0);
        for (k = 0; k < 3; k = k + 1)
        begin
            go(`TMR16_MODE_STOP);
            prescale_sel_i = rows[k][33:32];
            watch(4);
            check(count_value_o, 16'h0000);
            go(`TMR16_MODE_FREE);
            watch(64);
            check(count_value_o >= rows[k][31:16]
                && count_value_o <= rows[k][15:0], 1'b1);
        end
        go(`TMR16_MODE_STOP);
        prescale_sel_i = `TMR16_PSC_DIV2;
        period_capture_en_i = 1'b1;
        reverse_phase_capture_sel_i = 1'b1;
        second_edge_sel_i = `TMR16_ES_RISE;
        go(`TMR16_MODE_FREE);
        fork u_pins.pulse(1, 1'b1); watch(30); join
        check(n2, 0);
        fork u_pins.pulse(1, 1'b0); watch(40); join
        check(n2, 1);
        check(n1, 0);
        check(period_capture_reg_o > duty_capture_reg_o, 1'b1);
        saved = period_capture_reg_o;
        fork u_pins.pulse(2, 1'b0); watch(40); join
        check(n1, 1);
        check(period_capture_reg_o, saved);
        go(`TMR16_MODE_STOP);
        fork begin u_pins.pulse(1, 1'b0); u_pins.pulse(2, 1'b0); end watch(60); join
        check(n1 + n2, 0);
        period_capture_en_i = 1'b0;
        reverse_phase_capture_sel_i = 1'b0;
        out_enable_i = 1'b0;
        go(`TMR16_MODE_EDGE);
        fork begin u_pins.pulse(1, 1'b0); u_pins.pulse(1, 1'b0); end
            watch(60); join
        check(n2, 2);
        check(duty_capture_reg_o >= 16'h000A
            && duty_capture_reg_o <= 16'h000E, 1'b1);
        go(`TMR16_MODE_STOP);
        duty_capture_en_i = 1'b0;
        prescale_sel_i = `TMR16_PSC_PIN;
        go(`TMR16_MODE_FREE);
        fork begin u_pins.pulse(1, 1'b0); u_pins.pulse(1, 1'b0); end
            watch(55); join
        check(count_value_o, 16'h0002);
        go(`TMR16_MODE_STOP);
        prescale_sel_i = `TMR16_PSC_DIV2;
        wr(1'b1, 16'h0005);
        wr(1'b0, 16'h0003);
        out_enable_i = 1'b1;
        toggle_on_period_i = 1'b1;
        go(`TMR16_MODE_CMP);
        watch(100);
        check(cmax, 16'h0005);
        check(n1 >= 7, 1'b1);
        check(hi, 1'b1);
        overflow_clr_i = 1'b1;
        @(negedge ref_clk_i);
        overflow_clr_i = 1'b0;
        check(overflow_flag_o, 1'b0);
        go(`TMR16_MODE_STOP);
        out_enable_i = 1'b1;
        one_shot_en_i = 1'b1;
        go(`TMR16_MODE_CMP);
        fork trig; watch(60); join
        check(hi, 1'b0);
        go(`TMR16_MODE_STOP);
        watch(4);
        go(`TMR16_MODE_FREE);
        fork trig; watch(60); join
        check(hi, 1'b1);
        check(timer_output_pin_o, 1'b0);
        test_done;
    end
endmodule // tb_tmr16_core
